/* File: design/qsdd_defs.vh */
// constants for the quad-spi dummy and data phase sequencer
`ifndef QSDD_DEFS_VH
`define QSDD_DEFS_VH
// *****************************************************************
// data line width codes
// *****************************************************************
`define QSDD_DW_NONE 2'h0
`define QSDD_DW_ONE 2'h1
`define QSDD_DW_TWO 2'h2
`define QSDD_DW_FOUR 2'h3
// *****************************************************************
// functional modes
// *****************************************************************
`define QSDD_MODE_IND_WR 2'h0
`define QSDD_MODE_IND_RD 2'h1
`define QSDD_MODE_POLL 2'h2
`define QSDD_MODE_MMAP 2'h3
// *****************************************************************
// lengths and sizes
// *****************************************************************
`define QSDD_LEN_UNDEF 32'h0FFFFFFF
`define QSDD_POLL_MAX 32'h00000003
`define QSDD_FLASH_SIZE_FIELD_ENDLESS 5'h1F
`define QSDD_DUMMY_MAX 5'h1F
`define QSDD_DIV_DEFAULT 8'h01
`endif

/* File: design/qsdd_shifter.v */
// serial data shifter for one, two or four lines
`timescale 1ns/1ps
module qsdd_shifter (
  input wire clk,
  input wire arst_n,
  input wire load,
  input wire [7:0] load_byte,
  input wire shift,
  input wire [1:0] width,
  input wire [3:0] io_in,
  output reg [7:0] sh_reg,
  output reg [3:0] bits_left_reg
);
  reg [3:0] step;
  always @* begin
    case (width)
      2'h2: step = 4'h2;
      2'h3: step = 4'h4;
      default: step = 4'h1;
    endcase
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_reg <= 8'h00;
      bits_left_reg <= 4'h0;
    end else if (load) begin
      sh_reg <= load_byte;
      bits_left_reg <= 4'h8;
    end else if (shift && bits_left_reg != 4'h0) begin
      bits_left_reg <= bits_left_reg - step;
      case (width)
        2'h2: sh_reg <= {sh_reg[5:0], io_in[1:0]};
        2'h3: sh_reg <= {sh_reg[3:0], io_in};
        default: sh_reg <= {sh_reg[6:0], io_in[1]};
      endcase
    end
  end
endmodule // qsdd_shifter

/* File: design/qsdd_top.v */
// dummy-cycle and data-phase sequencer of a quad-spi flash interface
`timescale 1ns/1ps
`include "qsdd_defs.vh"
module qsdd_top #(
  parameter DIV = 8
) (
  input wire clk,
  input wire arst_n,
  input wire enable,
  input wire abort,
  input wire start,
  input wire [1:0] mode,
  input wire [4:0] dummy_cycle_count,
  input wire [1:0] data_line_width,
  input wire quad_pins,
  input wire wide_phases,
  input wire [31:0] data_length_register,
  input wire [4:0] flash_size_field,
  input wire [31:0] start_addr,
  input wire dual_memory_select,
  input wire [7:0] wr_data,
  input wire wr_valid,
  input wire rd_ready,
  input wire mm_req,
  input wire mm_last,
  input wire [3:0] io_in,
  output reg wr_ready,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg mm_err,
  output reg sclk,
  output reg [3:0] io_out,
  output reg [3:0] io_oe,
  output reg busy,
  output reg done,
  output reg [31:0] cur_addr,
  output reg dual_addr_same
);
  // *****************************************************************
  // states
  // *****************************************************************
  localparam S_IDLE = 3'h0;
  localparam S_DUMMY = 3'h1;
  localparam S_LOAD = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_HAND = 3'h4;
  localparam S_END = 3'h5;
  reg [2:0] state_reg;
  reg [7:0] div_reg;
  reg [4:0] dummy_reg;
  reg [31:0] left_reg;
  reg endless_reg;
  reg bounded_mem_reg;
  reg [31:0] end_addr_reg;
  reg [3:0] io_s1_reg;
  reg [3:0] io_s2_reg;
  reg sh_load;
  reg [7:0] sh_byte;
  wire [7:0] sh_val;
  wire [3:0] sh_left;
  wire tick;
  wire rise;
  wire is_rd;
  wire [31:0] fs_mask;
  wire [7:0] tx_byte;
  assign tick = (div_reg == DIV[7:0] - 8'h01);
  assign rise = tick && !sclk;
  assign is_rd = (mode != `QSDD_MODE_IND_WR);
  // first bits go out straight from the write port while loading
  assign tx_byte = (state_reg == S_LOAD) ? wr_data : sh_val;
  // flash holds 2^(size+1) bytes; size 0x1F is full 4 gb space
  assign fs_mask = (32'h00000002 << flash_size_field) - 32'h00000001;
  // *****************************************************************
  // input synchroniser
  // *****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_s1_reg <= 4'h0;
      io_s2_reg <= 4'h0;
    end else begin
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
    end
  end
  qsdd_shifter u_shift (
    .clk(clk),
    .arst_n(arst_n),
    .load(sh_load),
    .load_byte(sh_byte),
    .shift(rise && state_reg == S_DATA),
    .width(data_line_width),
    .io_in(io_s2_reg),
    .sh_reg(sh_val),
    .bits_left_reg(sh_left)
  );
  always @* begin
    sh_load = 1'b0;
    sh_byte = 8'h00;
    if (state_reg == S_LOAD) begin
      sh_load = is_rd || wr_valid;
      sh_byte = is_rd ? 8'h00 : wr_data;
    end
  end
  // *****************************************************************
  // sequencer
  // *****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      div_reg <= 8'h00;
      dummy_reg <= 5'h00;
      left_reg <= 32'h00000000;
      endless_reg <= 1'b0;
      bounded_mem_reg <= 1'b0;
      end_addr_reg <= 32'h00000000;
      sclk <= 1'b0;
      io_out <= 4'h0;
      io_oe <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      wr_ready <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      mm_err <= 1'b0;
      cur_addr <= 32'h00000000;
      dual_addr_same <= 1'b0;
    end else begin
      done <= 1'b0;
      wr_ready <= 1'b0;
      mm_err <= 1'b0;
      if (rd_valid && rd_ready)
        rd_valid <= 1'b0;
      if (state_reg != S_IDLE)
        div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      if (state_reg == S_DUMMY || state_reg == S_DATA) begin
        if (tick)
          sclk <= ~sclk;
      end else
        sclk <= 1'b0;
      if (!enable || abort) begin
        state_reg <= S_IDLE;
        busy <= 1'b0;
        io_oe <= 4'h0;
        sclk <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            div_reg <= 8'h00;
            if (start) begin
              busy <= 1'b1;
              cur_addr <= start_addr;
              // same address to both memories
              dual_addr_same <= dual_memory_select;
              endless_reg <= (data_length_register == `QSDD_LEN_UNDEF);
              bounded_mem_reg <= (flash_size_field != `QSDD_FLASH_SIZE_FIELD_ENDLESS);
              end_addr_reg <= fs_mask;
              if (mode == `QSDD_MODE_POLL &&
                  data_length_register > `QSDD_POLL_MAX)
                left_reg <= `QSDD_POLL_MAX;
              else
                left_reg <= data_length_register;
              if (mode == `QSDD_MODE_MMAP)
                left_reg <= 32'h00000000;
              dummy_reg <= dummy_cycle_count;
              if (dummy_cycle_count != 5'h00) begin
                state_reg <= S_DUMMY;
                if (quad_pins && wide_phases) begin
                  io_out <= 4'h8;
                  io_oe <= 4'hC;
                end else
                  io_oe <= 4'h0;
              end else if (data_line_width == `QSDD_DW_NONE)
                state_reg <= S_END;
              else
                state_reg <= S_LOAD;
            end
          end
          S_DUMMY: begin
            // count on falling edge: one full sclk period each
            if (tick && sclk) begin
              dummy_reg <= dummy_reg - 5'h01;
              if (dummy_reg == 5'h01) begin
                io_oe <= 4'h0;
                if (data_line_width == `QSDD_DW_NONE)
                  state_reg <= S_END;
                else
                  state_reg <= S_LOAD;
              end
            end
          end
          S_LOAD: begin
            if (!is_rd && wr_valid) begin
              wr_ready <= 1'b1;
              state_reg <= S_DATA;
            end else if (is_rd && !rd_valid)
              state_reg <= S_DATA;
          end
          S_DATA: begin
            if (sh_left == 4'h0 && !sclk)
              state_reg <= S_HAND;
          end
          S_HAND: begin
            if (is_rd) begin
              rd_data <= sh_val;
              rd_valid <= 1'b1;
            end
            cur_addr <= cur_addr + 32'h00000001;
            if (mode == `QSDD_MODE_MMAP) begin
              if (mm_last || !mm_req)
                state_reg <= S_END;
              else
                state_reg <= S_LOAD;
            end else if (endless_reg) begin
              if (bounded_mem_reg && cur_addr == end_addr_reg)
                state_reg <= S_END;
              else
                state_reg <= S_LOAD;
            end else if (left_reg == 32'h00000000)
              state_reg <= S_END;
            else begin
              left_reg <= left_reg - 32'h00000001;
              state_reg <= S_LOAD;
            end
          end
          S_END: begin
            busy <= 1'b0;
            done <= 1'b1;
            io_oe <= 4'h0;
            state_reg <= S_IDLE;
          end
          default: state_reg <= S_IDLE;
        endcase
        // lines move a clk after each rise, never on the sampling edge
        if (!is_rd && (state_reg == S_DATA ||
            (state_reg == S_LOAD && wr_valid))) begin
          case (data_line_width)
            `QSDD_DW_ONE: begin
              io_oe <= 4'h1;
              io_out <= {3'h0, tx_byte[7]};
            end
            `QSDD_DW_TWO: begin
              io_oe <= 4'h3;
              io_out <= {2'h0, tx_byte[7:6]};
            end
            default: begin
              io_oe <= 4'hF;
              io_out <= tx_byte[7:4];
            end
          endcase
        end else if (is_rd && state_reg == S_DATA)
          io_oe <= 4'h0;
      end
      // mapped window refuses writes
      if (mode == `QSDD_MODE_MMAP && wr_valid)
        mm_err <= 1'b1;
    end
  end
endmodule // qsdd_top

/* File: verif/qsdd_flash_model.sv */
// behavioural serial flash that answers reads on one, two or four lines
`timescale 1ns/1ps
module qsdd_flash_model (
  input wire sclk,
  input wire sel,
  input wire [1:0] width,
  input wire [4:0] dummy,
  input wire [3:0] din,
  output reg [15:0] got_reg,
  output wire [3:0] io
);
  // no chip select at the ports, so busy frames the transfer
  integer nxt_rise;
  reg [3:0] q_reg;
  function [3:0] sym(input integer r);
    integer w, d, i;
    reg [7:0] b;
    w = (width == 2'h3) ? 4 : width;
    d = dummy;
    i = (r - 1 - d) * w;
    b = (8'h3C + i / 8) >> (8 - i % 8 - w);
    if (i < 0) sym = 4'h6;
    else if (w == 1) sym = {4{b[0]}};
    else sym = (w == 2) ? {2'h0, b[1:0]} : b[3:0];
  endfunction
  always @(posedge sel) begin
    nxt_rise = 1;
    q_reg = sym(1);
    got_reg = 16'h0000;
  end
  // written bits are taken msb first at each rise after the dummy phase
  always @(posedge sclk) begin
    if (sel && nxt_rise > dummy) begin
      case (width)
        2'h3: got_reg = {got_reg[11:0], din};
        2'h2: got_reg = {got_reg[13:0], din[1:0]};
        default: got_reg = {got_reg[14:0], din[0]};
      endcase
    end
  end
  // new bits land on the falling edge, ahead of the next sampling rise
  always @(negedge sclk) begin
    if (sel) begin
      nxt_rise = nxt_rise + 1;
      q_reg = sym(nxt_rise);
    end
  end
  // released lines show the inverse of the last level, never a stale copy
  assign io = sel ? q_reg : ~q_reg;
endmodule // qsdd_flash_model

/* File: verif/qsdd_top_assertions.sv */
// assertion checker for the dummy and data phase sequencer
`timescale 1ns/1ps
module qsdd_top_assertions #(
  parameter DIV = 8
) (
  input wire clk,
  input wire arst_n,
  input wire abort,
  input wire start,
  input wire [1:0] mode,
  input wire [4:0] dummy_cycle_count,
  input wire [1:0] data_line_width,
  input wire quad_pins,
  input wire wide_phases,
  input wire wr_ready,
  input wire rd_valid,
  input wire sclk,
  input wire [3:0] io_out,
  input wire [3:0] io_oe,
  input wire busy,
  input wire done,
  input wire [31:0] cur_addr
);
  reg [15:0] cyc_reg;
  reg [15:0] hold_reg;
  reg sclk_q_reg;
  wire dum = busy && cyc_reg > 2 && cyc_reg + 2 < 2 * DIV * dummy_cycle_count;
  wire edg = sclk != sclk_q_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg <= 16'h0;
      hold_reg <= 16'h0;
      sclk_q_reg <= 1'h0;
    end else begin
      // saturate so a long stall cannot wrap the counts
      cyc_reg <= busy ? cyc_reg + {15'h0, ~&cyc_reg} : 16'h0;
      hold_reg <= edg ? 16'h1 : hold_reg + {15'h0, ~&hold_reg};
      sclk_q_reg <= sclk;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_start_busy:
    assert property (start && !abort && !busy |=> busy) else $error("no start");
  a_done_idle:
    assert property (done |-> !busy) else $error("done while busy");
  a_abort_stop:
    assert property (busy && abort |=> !busy && !done) else $error("no abort");
  a_sclk_rate:
    assert property (busy && cyc_reg > 2 * DIV && edg |->
      (dum ? hold_reg == DIV : hold_reg >= DIV)) else $error("sclk rate");
  a_dummy_pins:
    assert property (dum && quad_pins && wide_phases |->
      io_oe[3:2] == 2'h3 && io_out[3:2] == 2'h2) else $error("io2 io3");
  a_dummy_float:
    assert property (dum && !(quad_pins && wide_phases) |-> io_oe == 4'h0)
      else $error("io2 io3 driven");
  a_turn_around:
    assert property (dum && mode != 2'h0 |-> io_oe[1:0] == 2'h0 && !rd_valid)
      else $error("no turnaround");
  a_map_write:
    assert property (mode == 2'h3 |-> !wr_ready) else $error("mapped write");
  a_no_data:
    assert property (data_line_width == 2'h0 && mode == 2'h0 |->
      !wr_ready && !rd_valid) else $error("data without phase");
  a_addr_wrap:
    assert property (busy && $past(cur_addr) == 32'hFFFFFFFF &&
      cur_addr != 32'hFFFFFFFF |-> cur_addr == 32'h0) else $error("no wrap");
  cover property (dum && quad_pins && wide_phases);
  cover property (done && mode == 2'h3);
  cover property (busy && abort);
endmodule // qsdd_top_assertions
bind qsdd_top qsdd_top_assertions #(.DIV(DIV)) u_chk (.clk, .arst_n, .abort,
  .start, .mode, .dummy_cycle_count, .data_line_width, .quad_pins,
  .wide_phases, .wr_ready, .rd_valid, .sclk, .io_out, .io_oe, .busy, .done,
  .cur_addr);

/* File: verif/qsdd_top_tb.sv */
// self-checking bench for the dummy and data phase sequencer
`timescale 1ns/1ps
module qsdd_top_tb;
  reg clk = 1'h0, arst_n = 1'h0, enable = 1'h1, abort = 1'h0, start = 1'h0;
  reg quad_pins = 1'h1, wide_phases = 1'h1, dual_memory_select = 1'h0;
  reg wr_valid = 1'h1, rd_ready = 1'h1, mm_req = 1'h1, mm_last = 1'h0;
  reg [1:0] mode = 2'h0, data_line_width = 2'h0;
  reg [4:0] dummy_cycle_count = 5'h0, flash_size_field = 5'h1F;
  reg [31:0] data_length_register = 32'h0, start_addr = 32'h0;
  reg [7:0] wr_data = 8'h0;
  wire [3:0] io_in, io_out, io_oe;
  wire [15:0] flash_got;
  wire [7:0] rd_data;
  wire [31:0] cur_addr;
  wire wr_ready, rd_valid, mm_err, sclk, busy, done, dual_addr_same;
  integer bad_count = 0, comparisons = 0, n, w, seen_err = 0;
  qsdd_top #(.DIV(8)) dut (.clk, .arst_n, .enable, .abort, .start, .mode,
    .dummy_cycle_count, .data_line_width, .quad_pins, .wide_phases,
    .data_length_register, .flash_size_field, .start_addr,
    .dual_memory_select, .wr_data, .wr_valid, .rd_ready, .mm_req, .mm_last,
    .io_in, .wr_ready, .rd_data, .rd_valid, .mm_err, .sclk, .io_out, .io_oe,
    .busy, .done, .cur_addr, .dual_addr_same);
  qsdd_flash_model flash (.sclk, .sel(busy), .width(data_line_width),
    .dummy(dummy_cycle_count), .din(io_out), .got_reg(flash_got),
    .io(io_in));
  initial forever #12.5 clk = ~clk;
  task chk(input ok, input string msg);
    comparisons = comparisons + 1;
    if (ok !== 1'b1) begin
      bad_count = bad_count + 1;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task end_sim;
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one transfer; endless reads are cut by abort after lim bytes
  task run(input [1:0] m, dw, input [4:0] dc, input [31:0] len, a,
    input integer lim);
    integer t;
    mode = m;
    data_line_width = dw;
    dummy_cycle_count = dc;
    data_length_register = len;
    start_addr = a;
    n = 0;
    t = 0;
    mm_last = 1'h0;
    @(negedge clk);
    start = 1'h1;
    while (done !== 1'h1 && !abort && t < 30000) begin
      @(negedge clk);
      start = 1'h0;
      t = t + 1;
      if (mm_err === 1'h1) seen_err = 1;
      if (wr_ready === 1'h1) n = n + 1;
      if (rd_valid === 1'h1) begin
        chk(rd_data === 8'h3C + n[7:0], "read byte");
        n = n + 1;
      end
      wr_data = 8'h50 + n[7:0];
      mm_last = n >= lim - 1;
      abort = n >= lim && len == 32'h0FFFFFFF;
    end
    chk(t < 30000, "hang");
    repeat (2) @(negedge clk);
    abort = 1'h0;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'h1;
    for (w = 1; w < 4; w = w + 1) begin
      run(2'h0, w[1:0], 5'h0, 32'h1, 32'h0, 99);
      chk(n == 2 && flash_got === 16'h5051, "write count");
      run(2'h1, w[1:0], 5'h3, 32'h2, 32'h0, 99);
      chk(n == 3, "read count");
    end
    run(2'h1, 2'h3, 5'h1F, 32'h0, 32'h0, 99);
    chk(n == 1, "long dummy");
    quad_pins = 1'h0;
    run(2'h2, 2'h1, 5'h2, 32'h7, 32'h0, 99);
    chk(n == 4, "poll clamp");
    quad_pins = 1'h1;
    run(2'h0, 2'h0, 5'h0, 32'h5, 32'h0, 99);
    chk(n == 0, "no data");
    dual_memory_select = 1'h1;
    run(2'h3, 2'h3, 5'h2, 32'h0, 32'h0, 5);
    chk(n == 5 && seen_err == 1 && dual_addr_same === 1'h1,
      "mapped");
    flash_size_field = 5'h2;
    run(2'h1, 2'h2, 5'h0, 32'h0FFFFFFF, 32'h4, 99);
    chk(n == 4, "size end");
    flash_size_field = 5'h1F;
    run(2'h1, 2'h3, 5'h0, 32'h0FFFFFFF, 32'hFFFFFFFE, 4);
    chk(cur_addr[31:3] === 29'h0 && busy === 1'h0, "wrap");
    end_sim;
  end
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    end_sim;
  end
endmodule // qsdd_top_tb
